//--- logic/flash_pkg.sv
// constants and types shared by the serial flash status/read block
package flash_pkg;
  // command codes, arbitrary plain defaults
  localparam logic [7:0] CMD_READ  = 8'h03;
  localparam logic [7:0] CMD_FAST  = 8'h0B;
  localparam logic [7:0] CMD_SDDR  = 8'h0D;
  localparam logic [7:0] CMD_DUAL  = 8'hBB;
  localparam logic [7:0] CMD_DDDR  = 8'hBD;
  localparam logic [7:0] CMD_STATW = 8'h01;
  // frame lengths
  localparam logic [4:0] CMD_BITS    = 5'h08;
  localparam logic [4:0] ADDR_BITS   = 5'h18;
  localparam logic [4:0] BYTE_BITS   = 5'h08;
  localparam logic [4:0] DUMMY_FAST  = 5'h08;
  localparam logic [4:0] DUMMY_SDDR  = 5'h06;
  localparam logic [4:0] DUMMY_DUAL  = 5'h04;
  localparam logic [4:0] DUMMY_DDDR  = 5'h06;
  // status register layout
  localparam int LOCK_BIT  = 7;
  localparam int QUAD_BIT  = 6;
  localparam int BP_HI     = 5;
  localparam int BP_LO     = 2;
  localparam int LATCH_BIT = 1;
  localparam int BUSY_BIT  = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // synchroniser lanes
  localparam int PIN_CS   = 4;
  localparam int PIN_SCLK = 3;
  localparam int PIN_WP   = 2;
  localparam int PIN_IO1  = 1;
  localparam int PIN_IO0  = 0;
  // status write cycle time
  localparam int CLK_NS          = 10;
  localparam int STATUS_WRITE_NS = 40;
  localparam int STATUS_WRITE_CYC =
    (STATUS_WRITE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_STAT, ST_SKIP
  } phase_type;

  typedef enum logic [2:0] {
    RD_BASIC, RD_FAST, RD_SDDR, RD_DUAL, RD_DDDR, WR_STAT
  } mode_type;
endpackage : flash_pkg

//--- logic/serial_flash_core.sv
// serial flash status write, protection modes and array read paths
// What this block does
// - status write loads lock, quad and protect bits; latch and busy kept
// - status write refused while hardware protection is active
// - status write needs deselect exactly on a byte boundary
// - accepted write runs timed cycle with busy, then clears busy, latch
// - program or erase on protected area is refused
// - hardware protection entered whichever condition came first
// - hardware protection left only by driving protect pin high
// - quad mode disables hardware protection completely
// - basic read: command, 3 address bytes, data on falling edges
// - address increments after each byte, wraps to zero at top
// - deselect during data ends the read and stops driving
// - fast read: address, one dummy byte, data on falling edges
// - fast, ddr and dual reads refused while a cycle runs
// - single ddr read: address both edges, 6 dummies, data both edges
// - dual read: address two lines, 4 dummies, data two lines
// - dual ddr read: 4 bits a clock, 6 dummies, 4 bits data a clock
// - status: lock, quad, four protect, latch, busy from bit 7 down
// - quad flag turns shared protect and hold pins into data lines
`timescale 1ns/10ps
module serial_flash_core
  import flash_pkg::*;
#(
  parameter int AW        = 8,
  parameter int WR_CYCLES = STATUS_WRITE_CYC
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // flash pins
  input  wire logic            csN,
  input  wire logic            sclk,
  input  wire logic            wpN,
  input  wire logic            io0In,
  input  wire logic            io1In,
  output logic                 io0Out,
  output logic                 io0Oe,
  output logic                 io1Out,
  output logic                 io1Oe,
  // neighbouring command logic
  input  wire logic            latchSet,
  input  wire logic            arrayBusy,
  input  wire logic            arrayReq,
  input  wire logic            areaProtected,
  output logic                 arrayAccept,
  // array contents loader
  input  wire logic            memLoadEn,
  input  wire logic [AW-1:0]   memLoadAddr,
  input  wire logic [7:0]      memLoadData,
  // status
  output logic [7:0]           statusOut,
  output logic                 hwProtectMode,
  output logic                 sharedPinsData
);

  typedef struct packed {
    logic [4:0]  syncA;
    logic [4:0]  syncB;
    logic        prevCs;
    logic        prevSclk;
    phase_type   phase;
    mode_type    mode;
    logic [7:0]  cmd;
    logic [7:0]  sh;
    logic [7:0]  stat;
    logic [23:0] addr;
    logic [4:0]  cnt;
    logic        bad;
    logic [15:0] timer;
    logic [1:0]  dout;
    logic [1:0]  doe;
  } core_type;

  // sclk lane resets to its idle low, so no false edge follows reset
  localparam core_type CORE_RESET = '{
    syncA: 5'h17, syncB: 5'h17, prevCs: 1'b1, prevSclk: 1'b0,
    phase: ST_CMD, mode: RD_BASIC, cmd: 8'h00, sh: 8'h00,
    stat: STATUS_RESET, addr: 24'h000000, cnt: 5'h00, bad: 1'b0,
    timer: 16'h0000, dout: 2'h0, doe: 2'h0};

  core_type   coreReg;
  core_type   coreNext;
  logic [7:0] mem [2**AW];

  // *************************************************************
  // helpers
  // *************************************************************
  function automatic logic [4:0] laneWidth(input mode_type m);
    laneWidth = (m == RD_DUAL || m == RD_DDDR) ? 5'h02 : 5'h01;
  endfunction : laneWidth

  function automatic logic isDdr(input mode_type m);
    isDdr = (m == RD_SDDR || m == RD_DDDR);
  endfunction : isDdr

  function automatic logic [4:0] dummyOf(input mode_type m);
    unique case (m)
      RD_FAST: dummyOf = DUMMY_FAST;
      RD_SDDR: dummyOf = DUMMY_SDDR;
      RD_DUAL: dummyOf = DUMMY_DUAL;
      RD_DDDR: dummyOf = DUMMY_DDDR;
      default: dummyOf = 5'h00;
    endcase
  endfunction : dummyOf

  // wraps at the top of the array
  function automatic logic [23:0] nextAddr(input logic [23:0] a);
    logic [AW-1:0] t;
    t = a[AW-1:0] + 1'b1;
    nextAddr = 24'(t);
  endfunction : nextAddr

  // *************************************************************
  // sampled pins and edges
  // *************************************************************
  logic csHigh, csRise, rise, fall, io0S, io1S, wpS;
  logic wide, ddr, busyAll, hwProtect;
  logic [4:0] w;
  assign csHigh = coreReg.syncB[PIN_CS];
  assign csRise = csHigh & ~coreReg.prevCs;
  assign rise   = coreReg.syncB[PIN_SCLK] & ~coreReg.prevSclk;
  assign fall   = ~coreReg.syncB[PIN_SCLK] & coreReg.prevSclk;
  assign io0S   = coreReg.syncB[PIN_IO0];
  assign io1S   = coreReg.syncB[PIN_IO1];
  assign wpS    = coreReg.syncB[PIN_WP];
  assign w      = laneWidth(coreReg.mode);
  assign wide   = (w == 5'h02);
  assign ddr    = isDdr(coreReg.mode);
  assign busyAll = coreReg.stat[BUSY_BIT] | arrayBusy;
  // level-based, so entry order of pin and lock does not matter
  assign hwProtect = ~wpS & coreReg.stat[LOCK_BIT]
                     & ~coreReg.stat[QUAD_BIT];

  // *************************************************************
  // next state
  // *************************************************************
  always_comb begin
    logic [7:0]  c8;
    logic [23:0] aNew;
    logic        inEdge;
    c8 = {coreReg.cmd[6:0], io0S};
    aNew = wide ? {coreReg.addr[21:0], io1S, io0S}
                : {coreReg.addr[22:0], io0S};
    // ddr falls count only after the rise of the same clock
    inEdge = rise | (fall & ddr & (|(coreReg.cnt & w)));
    coreNext = coreReg;
    coreNext.syncA = {csN, sclk, wpN, io1In, io0In};
    coreNext.syncB = coreReg.syncA;
    coreNext.prevCs = coreReg.syncB[PIN_CS];
    coreNext.prevSclk = coreReg.syncB[PIN_SCLK];
    if (coreReg.stat[BUSY_BIT]) begin
      if (coreReg.timer == 16'h0000) begin
        coreNext.stat[BUSY_BIT] = 1'b0;
        coreNext.stat[LATCH_BIT] = 1'b0;
      end else begin
        coreNext.timer = coreReg.timer - 16'h0001;
      end
    end
    if (csHigh) begin
      coreNext.phase = ST_CMD;
      coreNext.cnt = 5'h00;
      coreNext.bad = 1'b0;
      coreNext.doe = 2'h0;
      // anything short of a clean single byte is dropped
      if (csRise && coreReg.phase == ST_STAT && !coreReg.bad
          && coreReg.cnt == BYTE_BITS
          && coreReg.stat[LATCH_BIT] && !hwProtect
          && !coreReg.stat[BUSY_BIT]) begin
        coreNext.stat[7:2] = coreReg.sh[7:2];
        coreNext.stat[BUSY_BIT] = 1'b1;
        coreNext.timer = 16'(WR_CYCLES - 1);
      end
    end else begin
      unique case (coreReg.phase)
        ST_CMD: begin
          if (rise) begin
            coreNext.cmd = c8;
            coreNext.cnt = coreReg.cnt + 5'h01;
            if (coreNext.cnt == CMD_BITS) begin
              coreNext.cnt = 5'h00;
              coreNext.phase = ST_ADDR;
              unique case (c8)
                CMD_READ: coreNext.mode = RD_BASIC;
                CMD_FAST: coreNext.mode = RD_FAST;
                CMD_SDDR: coreNext.mode = RD_SDDR;
                CMD_DUAL: coreNext.mode = RD_DUAL;
                CMD_DDDR: coreNext.mode = RD_DDDR;
                CMD_STATW: begin
                  coreNext.mode = WR_STAT;
                  coreNext.phase = ST_STAT;
                end
                default: coreNext.phase = ST_SKIP;
              endcase
              if (busyAll && c8 != CMD_READ)
                coreNext.phase = ST_SKIP;
            end
          end
        end
        ST_ADDR: begin
          if (inEdge) begin
            coreNext.addr = aNew;
            coreNext.cnt = coreReg.cnt + w;
            if (coreNext.cnt == ADDR_BITS) begin
              coreNext.cnt = 5'h00;
              if (dummyOf(coreReg.mode) == 5'h00) begin
                coreNext.phase = ST_DATA;
                coreNext.sh = mem[aNew[AW-1:0]];
                coreNext.addr = nextAddr(aNew);
              end else begin
                coreNext.phase = ST_DUMMY;
              end
            end
          end
        end
        ST_DUMMY: begin
          if (rise) begin
            coreNext.cnt = coreReg.cnt + 5'h01;
            if (coreNext.cnt == dummyOf(coreReg.mode)) begin
              coreNext.cnt = 5'h00;
              coreNext.phase = ST_DATA;
              coreNext.sh = mem[coreReg.addr[AW-1:0]];
              coreNext.addr = nextAddr(coreReg.addr);
            end
          end
        end
        ST_DATA: begin
          if (fall || (ddr && rise)) begin
            coreNext.dout = {coreReg.sh[7], wide & coreReg.sh[6]};
            coreNext.doe = {1'b1, wide};
            coreNext.sh = wide ? {coreReg.sh[5:0], 2'h0}
                               : {coreReg.sh[6:0], 1'b0};
            coreNext.cnt = coreReg.cnt + w;
            if (coreNext.cnt == BYTE_BITS) begin
              coreNext.cnt = 5'h00;
              coreNext.sh = mem[coreReg.addr[AW-1:0]];
              coreNext.addr = nextAddr(coreReg.addr);
            end
          end
        end
        ST_STAT: begin
          if (rise) begin
            if (coreReg.cnt == BYTE_BITS) begin
              coreNext.bad = 1'b1;
            end else begin
              coreNext.sh = {coreReg.sh[6:0], io0S};
              coreNext.cnt = coreReg.cnt + 5'h01;
            end
          end
        end
        ST_SKIP: begin
        end
      endcase
    end
    // set wins over the end-of-cycle clear
    if (latchSet)
      coreNext.stat[LATCH_BIT] = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      coreReg <= CORE_RESET;
    else
      coreReg <= coreNext;
  end

  // array storage has no reset; contents come from the loader
  always_ff @(posedge clk) begin
    if (memLoadEn)
      mem[memLoadAddr] <= memLoadData;
  end

  // *************************************************************
  // outputs
  // *************************************************************
  assign io1Out = coreReg.dout[1];
  assign io0Out = coreReg.dout[0];
  assign io1Oe = coreReg.doe[1];
  assign io0Oe = coreReg.doe[0];
  assign statusOut = coreReg.stat;
  assign hwProtectMode = hwProtect;
  assign sharedPinsData = coreReg.stat[QUAD_BIT];
  assign arrayAccept = arrayReq & coreReg.stat[LATCH_BIT]
                       & ~areaProtected;

  // *************************************************************
  // assertions
  // *************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic c8Fast;
  assign c8Fast = {coreReg.cmd[6:0], io0S} == CMD_FAST;

  stat_load_a: assert property ($rose(coreReg.stat[BUSY_BIT]) |->
    coreReg.stat[7:2] == $past(coreReg.sh[7:2]))
    else $error("status byte not loaded");
  hwp_refuse_a: assert property (csRise && hwProtect |=>
    $stable(coreReg.stat[7:2]) && !$rose(coreReg.stat[BUSY_BIT]))
    else $error("status write taken in hardware protection");
  boundary_a: assert property (csRise && coreReg.cnt != BYTE_BITS |=>
    !$rose(coreReg.stat[BUSY_BIT]))
    else $error("status write off byte boundary taken");
  busy_hold_a: assert property ($rose(coreReg.stat[BUSY_BIT]) |->
    coreReg.stat[BUSY_BIT] [*3])
    else $error("busy dropped early");
  busy_end_a: assert property ($fell(coreReg.stat[BUSY_BIT]) &&
    !$past(latchSet) |-> !coreReg.stat[LATCH_BIT])
    else $error("latch not cleared at end of cycle");
  quad_off_a: assert property (coreReg.stat[QUAD_BIT] |->
    !hwProtectMode)
    else $error("hardware protection in quad mode");
  area_a: assert property (arrayReq && areaProtected |->
    !arrayAccept)
    else $error("protected area write accepted");
  wrap_a: assert property (coreReg.phase == ST_DATA &&
    $past(coreReg.phase) == ST_DATA && $changed(coreReg.addr) |->
    coreReg.addr[AW-1:0] == AW'($past(coreReg.addr[AW-1:0]) + 1'b1))
    else $error("read address not incremented");
  cs_stop_a: assert property (csRise |=> coreReg.doe == 2'h0)
    else $error("still driving after deselect");
  busy_rej_a: assert property (coreReg.phase == ST_CMD && busyAll &&
    rise && !csHigh && coreReg.cnt == 5'h07 && c8Fast |=>
    coreReg.phase == ST_SKIP)
    else $error("fast read taken while busy");
  refuse_a: assert property (csRise && !coreReg.stat[LATCH_BIT] |=>
    $stable(coreReg.stat[7:2]) && !coreReg.stat[BUSY_BIT]
    || $past(coreReg.stat[BUSY_BIT]))
    else $error("refused status write changed state");

  cov_write_c: cover property ($rose(coreReg.stat[BUSY_BIT]));
  cov_dual_c: cover property (coreReg.phase == ST_DATA && wide);
  cov_ddr_c: cover property (coreReg.phase == ST_DATA && ddr);
  cov_hwp_c: cover property (csRise && hwProtect);
endmodule : serial_flash_core

//--- verif/serial_flash_status_write_and_read_paths_tb.sv
// self-checking bench for the serial flash status and read paths
`timescale 1ns/10ps
module serial_flash_status_write_and_read_paths_tb
  import flash_pkg::*;
;
  // ********************************
  // stimulus, model and checks
  // ********************************
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic csN, sclk, hostIo0, hostIo1, rdValid;
  logic [7:0] rdByte, statusOut, expB;
  logic wpN = 1'h1;
  logic latchSet = 1'h0;
  logic arrayBusy = 1'h0;
  logic arrayReq = 1'h0;
  logic areaProtected = 1'h0;
  logic memLoadEn = 1'h0;
  logic [7:0] memLoadAddr = 8'h00;
  logic [7:0] memLoadData = 8'h00;
  logic io0Out, io0Oe, io1Out, io1Oe, arrayAccept, hwProtectMode;
  logic sharedPinsData;
  logic [7:0] mem [256];
  logic [7:0] expQ [$];
  logic [7:0] cmds [5] = '{CMD_READ, CMD_FAST, CMD_SDDR, CMD_DUAL, CMD_DDDR};
  int bad_count = 0;
  int checks = 0;
  int seed = 58;
  int oeRises = 0;
  int oeBase;
  wire io0Line = io0Oe ? io0Out : hostIo0;
  wire io1Line = io1Oe ? io1Out : hostIo1;

  always #5 clk = ~clk;
  always @(posedge io1Oe or posedge io0Oe) oeRises++;

  serial_flash_core #(.AW(8), .WR_CYCLES(1000)) uut (
    .clk(clk), .rst_n(rst_n), .csN(csN), .sclk(sclk), .wpN(wpN),
    .io0In(io0Line), .io1In(io1Line), .io0Out(io0Out), .io0Oe(io0Oe),
    .io1Out(io1Out), .io1Oe(io1Oe), .latchSet(latchSet),
    .arrayBusy(arrayBusy), .arrayReq(arrayReq),
    .areaProtected(areaProtected), .arrayAccept(arrayAccept),
    .memLoadEn(memLoadEn), .memLoadAddr(memLoadAddr),
    .memLoadData(memLoadData), .statusOut(statusOut),
    .hwProtectMode(hwProtectMode), .sharedPinsData(sharedPinsData));

  spi_host_model host (
    .csN(csN), .sclk(sclk), .io0(hostIo0), .io1(hostIo1),
    .io0Line(io0Line), .io1Line(io1Line), .rdValid(rdValid),
    .rdByte(rdByte));

  task automatic stop_test();
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t read byte %h expected %h", $time, got, exp);
    end
  endtask : compare_byte

  task automatic compare_stat(input logic [7:0] exp);
    checks++;
    if (statusOut !== exp) begin
      bad_count++;
      $display("[FAIL] %0t status %h expected %h", $time, statusOut, exp);
    end
  endtask : compare_stat

  task automatic compare_bit(input logic got, input logic exp, string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t flag %s wrong", $time, what);
    end
  endtask : compare_bit

  always @(posedge rdValid) begin
    expB = expQ.size() > 0 ? expQ.pop_front() : 8'hXX;
    compare_byte(rdByte, expB);
  end

  task automatic rd(input int kind, input logic [7:0] adr, input int nb);
    for (int i = 0; i < nb; i++)
      expQ.push_back(mem[8'(adr + i)]);
    host.read(kind, cmds[kind], {16'h0000, adr}, nb, 1'h1);
  endtask : rd

  task automatic pulse_latch();
    @(posedge clk) latchSet <= 1'h1;
    @(posedge clk) latchSet <= 1'h0;
  endtask : pulse_latch

  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask : settle

  // busy stands 1000 clk, so a fast read fits inside the cycle
  task automatic wrs(input logic [8:0] v, input int n, input logic [7:0] dur,
                     input logic [7:0] aft, input bit busyRead);
    host.stat(v, n);
    compare_stat(dur);
    if (busyRead) begin
      oeBase = oeRises;
      host.read(1, CMD_FAST, 24'h000000, 1, 1'h0);
      compare_bit(oeRises == oeBase, 1'h1, "read during write");
    end
    for (int t = 0; t < 1200 && statusOut[BUSY_BIT] !== 1'h0; t++)
      @(posedge clk);
    #1;
    compare_stat(aft);
  endtask : wrs

  initial begin
    repeat (20) @(posedge clk);
    compare_stat(STATUS_RESET);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 256; i++) begin
      @(posedge clk);
      mem[i] = 8'($random(seed));
      memLoadEn <= 1'h1;
      memLoadAddr <= 8'(i);
      memLoadData <= mem[i];
    end
    @(posedge clk) memLoadEn <= 1'h0;
    for (int k = 0; k < 5; k++) begin
      rd(k, 8'hFE, 3);
      compare_bit(io1Oe | io0Oe, 1'h0, "drive after deselect");
    end
    @(posedge clk) arrayBusy <= 1'h1;
    oeBase = oeRises;
    for (int k = 1; k < 5; k++)
      host.read(k, cmds[k], 24'h000000, 1, 1'h0);
    compare_bit(oeRises == oeBase, 1'h1, "read while busy");
    rd(0, 8'h10, 1);
    arrayBusy <= 1'h0;
    wrs(9'h0BC, 8, 8'h00, 8'h00, 1'h0);
    pulse_latch();
    wrs(9'h05E, 7, 8'h02, 8'h02, 1'h0);
    wrs(9'h179, 9, 8'h02, 8'h02, 1'h0);
    wrs(9'h0BF, 8, 8'hBF, 8'hBC, 1'h1);
    wpN <= 1'h0;
    settle();
    compare_bit(hwProtectMode, 1'h1, "hw protect");
    pulse_latch();
    wrs(9'h000, 8, 8'hBE, 8'hBE, 1'h0);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      arrayReq <= c[1];
      areaProtected <= c[0];
      settle();
      compare_bit(arrayAccept, c == 2, "array accept");
    end
    wpN <= 1'h1;
    settle();
    compare_bit(hwProtectMode, 1'h0, "protect left");
    wrs(9'h0C0, 8, 8'hC3, 8'hC0, 1'h0);
    compare_bit(sharedPinsData, 1'h1, "shared pins");
    wpN <= 1'h0;
    settle();
    compare_bit(hwProtectMode, 1'h0, "quad protect");
    pulse_latch();
    wrs(9'h000, 8, 8'h03, 8'h00, 1'h0);
    pulse_latch();
    wrs(9'h080, 8, 8'h83, 8'h80, 1'h0);
    compare_bit(hwProtectMode, 1'h1, "pin low first");
    stop_test();
  end

  // the whole sequence needs about 110 us
  initial begin
    #800000;
    bad_count++;
    stop_test();
  end
endmodule : serial_flash_status_write_and_read_paths_tb

//--- verif/spi_host_model.sv
// host controller model that frames commands on the serial flash pin link
`timescale 1ns/10ps
module spi_host_model
  import flash_pkg::*;
(
  // pin link
  output logic       csN,
  output logic       sclk,
  output logic       io0,
  output logic       io1,
  input  wire logic  io0Line,
  input  wire logic  io1Line,
  // collected read bytes
  output logic       rdValid,
  output logic [7:0] rdByte
);
  // ********************************
  // half periods of a 125 ns link clock
  // ********************************
  bit rel;

  initial begin
    csN = 1'h1;
    sclk = 1'h0;
    io0 = 1'h0;
    io1 = 1'h0;
    rdValid = 1'h0;
    rdByte = 8'h00;
    rel = 1'h0;
  end

  // released lines toggle so a missing driver never reads as a match
  task automatic half(input logic d1, input logic d0, output logic s1,
                      output logic s0);
    #31.25;
    io1 = rel ? ~io1 : d1;
    io0 = rel ? ~io0 : d0;
    #31.25;
    s1 = io1Line;
    s0 = io0Line;
    sclk = ~sclk;
  endtask : half

  // msb first, w bits a unit; sdr units held over the falling half
  task automatic send(input logic [23:0] v, input int n, input int w,
                      input bit ddr);
    logic a;
    logic b;
    int   i;
    i = n;
    while (i > 0) begin
      half(w == 2 ? v[i-1] : 1'h0, v[i-w], a, b);
      if (ddr)
        i -= w;
      half(w == 2 ? v[i-1] : 1'h0, v[i-w], a, b);
      i -= w;
    end
  endtask : send

  task automatic recv(input int nb, input int w, input bit ddr,
                      input bit take);
    logic       a;
    logic       b;
    logic [7:0] by;
    rel = 1'h1;
    repeat (nb) begin
      for (int j = 0; j < (ddr ? 8 / w : 16 / w); j++) begin
        half(1'h0, 1'h0, a, b);
        if (ddr || j % 2 == 0)
          by = (w == 2) ? {by[5:0], a, b} : {by[6:0], a};
      end
      rdByte = by;
      rdValid = take;
      #1;
      rdValid = 1'h0;
    end
  endtask : recv

  task automatic done();
    #31.25;
    csN = 1'h1;
    rel = 1'h0;
    #100;
  endtask : done

  task automatic read(input int kind, input logic [7:0] cmd,
                      input logic [23:0] addr, input int nb, input bit take);
    csN = 1'h0;
    send({16'h0000, cmd}, 8, 1, 1'h0);
    send(addr, 24, kind >= 3 ? 2 : 1, kind == 2 || kind == 4);
    if (kind != 0)
      send(24'h000000, kind == 2 || kind == 4 ? 6 : 8, kind == 3 ? 2 : 1,
           1'h0);
    recv(nb, kind >= 3 ? 2 : 1, kind == 2 || kind == 4, take);
    done();
  endtask : read

  // n other than 8 ends the frame off a byte boundary
  task automatic stat(input logic [8:0] v, input int n);
    csN = 1'h0;
    send({16'h0000, CMD_STATW}, 8, 1, 1'h0);
    send({15'h0000, v}, n, 1, 1'h0);
    done();
  endtask : stat
endmodule : spi_host_model
